//--- mp_ext_model.sv
// board-side model: drives input pins and an external clock, captures output slices
// assumes a pull-up on every pin and a 4-bit port
`timescale 1ns/10ps
`default_nettype none
module mp_ext_model (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic [3:0]  pin_out,
   input  wire logic [3:0]  pin_oe_n,
   input  wire logic        strobe_to_external,
   input  wire logic [3:0]  in_val,
   input  wire logic        ext_en,
   input  wire logic        cap_clr,
   output logic      [3:0]  pin_in,
   output logic      [5:0]  cb_pin_src,
   output logic             strobe_from_external,
   output logic      [31:0] cap_word,
   output logic      [3:0]  cap_n
);
   logic [3:0] wire_lvl;
   logic       div_q;
   logic       ext_q;
   // released pins float up, so open drain reads back the driven bit
   assign wire_lvl = pin_out | pin_oe_n;
   assign pin_in = in_val;
   // input strobe follows the board clock, low while that clock is stopped
   assign strobe_from_external = ext_en & ext_q;
   assign cb_pin_src = {6{ext_q}};
   // external clock, period four cycles, stands still when not wanted
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst) begin div_q <= 1'b0; ext_q <= 1'b0; end
      else if (ext_en) begin div_q <= ~div_q; if (div_q) ext_q <= ~ext_q; end
   end
   // slices arrive least significant first, one per strobe
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         cap_word <= 32'h0;
         cap_n    <= 4'h0;
      end
      else if (cap_clr)
      begin
         cap_word <= 32'h0;
         cap_n    <= 4'h0;
      end
      else if (strobe_to_external)
      begin
         cap_word <= {wire_lvl, cap_word[31:4]};
         cap_n <= cap_n + 4'h1;
      end
   end
endmodule : mp_ext_model
`default_nettype wire

//--- mp_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock and an asynchronous active high reset
`timescale 1ns/10ps
`default_nettype none
module mp_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             flush,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [CW-1:0]    cnt_q;
   logic             push;
   logic             pop;

   // honest full and empty from the fill count
   assign in_ready  = (cnt_q != CW'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // storage, no reset needed on data
   always_ff @(posedge clk_sys)
   begin
      if (push)
         mem_q[wr_q] <= in_data;
   end

   // pointers wrap at depth, not at a power of two
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else if (flush)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         if (pop)
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         if (push && !pop)
            cnt_q <= cnt_q + 1'b1;
         else if (pop && !push)
            cnt_q <= cnt_q - 1'b1;
      end
   end
endmodule : mp_fifo
`default_nettype wire

//--- mp_params.svh
// timing counts, resets and field sizes for the multiwidth port block
// assumes it is included by bare name from each design file
//
// Overview of operation
// - ports come in widths 1, 4, 8, 16 or 32 bits toward pins
// - all pins of one port share a single direction
// - port drives pins high or low, or samples them, optionally on a condition
// - each core access to the port completes in one cycle; here a write waits while the fifo is full and a read while it is empty
// - open drain mode pulls low on zero, floats on one, per port
// - data passes through a serialiser and transfer register buffer
// - a 16-bit port counter can time transfers to the transfer register
// - counter readable always; a transfer can wait for a future count
// - each transfer captures the counter as a timestamp
// - an enabled link disables the port on shared pins
// - an enabled narrower port takes shared pins from a wider port
// - pins not taken by a narrower port stay with the wider port
// - a port always transfers at its full nominal width
// - six clock blocks; block zero is the tile reference clock
// - clock blocks set the transfer rate of attached ports
// - a clock block may run from a 1-bit port input, optionally divided
// - ports accept input strobes and generate output strobes
// - after reset every port is attached to clock block 0
// - pin events go straight to the event scheduler, not interrupts
// - while in reset every pin has its pull-down enabled
`ifndef MP_PARAMS_SVH
`define MP_PARAMS_SVH
`define MP_CNT_W     16
`define MP_XFER_W    32
`define MP_NUM_CB    6
`define MP_CB_SEL_W  3
`define MP_DIV_W     8
`define MP_RST_CB    3'h0
`define MP_FIFO_DEP  4
`define MP_PORT_W    4
`endif

//--- mp_pkg.sv
// shared types for the multiwidth port block
// assumes mp_params.svh sits in the same folder
`include "mp_params.svh"
package mp_pkg;
   // sampling condition held against the pins
   typedef enum logic [1:0] {
      MP_COND_NONE = 2'b00,
      MP_COND_EQ   = 2'b01,
      MP_COND_NEQ  = 2'b10
   } mp_cond_t;

   // per-port configuration, all level signals
   typedef struct packed {
      logic                    enable;
      logic                    dir_out;
      logic                    open_drain;
      logic [`MP_CB_SEL_W-1:0] clk_sel;
      mp_cond_t                cond;
      logic [`MP_XFER_W-1:0]   cond_val;
      logic                    strobe_in_en;
      logic                    strobe_out_en;
      logic                    timed;
      logic [`MP_CNT_W-1:0]    time_val;
   } mp_port_cfg_t;

   // per-clock-block configuration
   typedef struct packed {
      logic                 from_pin;
      logic [`MP_DIV_W-1:0] div;
   } mp_cb_cfg_t;
endpackage : mp_pkg

//--- mp_port.sv
// one hardware response port with its six clock blocks
// assumes pin inputs are synchronous to clk_sys; pads resolve out/oe_n
`timescale 1ns/10ps
`default_nettype none
`include "mp_params.svh"
module mp_port #(
   parameter int W     = `MP_PORT_W,
   parameter int DEPTH = `MP_FIFO_DEP
) (
   input  wire logic                          clk_sys,
   input  wire logic                          rst,
   input  wire mp_pkg::mp_port_cfg_t          port_cfg,
   input  wire mp_pkg::mp_cb_cfg_t [`MP_NUM_CB-1:0] cb_cfg,
   input  wire logic [`MP_NUM_CB-1:0]         cb_pin_src,
   input  wire logic                          link_en,
   input  wire logic [W-1:0]                  narrower_own,
   input  wire logic                          core_wr_valid,
   output logic                               core_wr_ready,
   input  wire logic [`MP_XFER_W-1:0]         core_wr_data,
   output logic                               core_rd_valid,
   input  wire logic                          core_rd_ready,
   output logic [`MP_XFER_W-1:0]              core_rd_data,
   output logic [`MP_CNT_W-1:0]               port_count,
   output logic [`MP_CNT_W-1:0]               timestamp,
   output logic                               pin_event,
   input  wire logic [W-1:0]                  pin_in,
   output logic [W-1:0]                       pin_out,
   output logic [W-1:0]                       pin_oe_n,
   output logic                               pin_pulldown,
   input  wire logic                          strobe_from_external,
   output logic                               strobe_to_external
);
   localparam int XW  = `MP_XFER_W;
   localparam int NCB = `MP_NUM_CB;
   localparam int SHN = XW / W;
   localparam logic [5:0] LAST = 6'(SHN - 1);

   // clock block ticks
   logic [NCB-1:0]         cb_tick;
   logic [NCB-1:0]         src_q;
   logic                   tick;

   // port counter and live state
   logic [`MP_CNT_W-1:0]   count_q;
   logic                   live;
   logic                   time_ok;

   // serialiser / deserialiser
   logic [XW-1:0]          sh_q;
   logic [5:0]             left_q;
   logic [W-1:0]           drv_q;
   logic                   wfull_q;
   logic [5:0]             nin_q;
   logic                   cond_ok;
   logic                   samp;
   logic                   stb_q;
   logic                   evt_q;
   logic [`MP_CNT_W-1:0]   ts_q;

   // fifo wiring
   logic                   f_in_valid;
   logic                   f_in_ready;
   logic [XW-1:0]          f_in_data;
   logic                   f_out_valid;
   logic                   f_out_ready;
   logic [XW-1:0]          f_out_data;
   logic                   load;
   logic [W-1:0]           drive;

   // a port counts only while enabled and not displaced by a link
   assign live = port_cfg.enable && !link_en;

   // pin source history for edge detection on the clock inputs
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         src_q <= '0;
      else
         src_q <= cb_pin_src;
   end

   // one divider per clock block; block zero is the bare reference
   generate
      for (genvar i = 0; i < NCB; i++)
      begin : g_cb
         logic [`MP_DIV_W-1:0] div_q;
         logic                 src_edge;
         if (i == 0)
         begin : g_ref
            assign src_edge = 1'b1;
            assign cb_tick[i] = 1'b1;
            always_ff @(posedge clk_sys or posedge rst)
            begin
               if (rst)
                  div_q <= '0;
               else
                  div_q <= '0;
            end
         end
         else
         begin : g_prog
            // rising edge of a 1-bit port input, or every reference cycle
            assign src_edge = cb_cfg[i].from_pin ?
                              (cb_pin_src[i] && !src_q[i]) : 1'b1;
            assign cb_tick[i] = src_edge && (div_q == cb_cfg[i].div);
            always_ff @(posedge clk_sys or posedge rst)
            begin
               if (rst)
                  div_q <= '0;
               else if (cb_tick[i])
                  div_q <= '0;
               else if (src_edge)
                  div_q <= div_q + 1'b1;
            end
         end
      end
   endgenerate

   // the selected block paces every transfer of this port
   assign tick = live && (port_cfg.clk_sel < 3'(NCB)) &&
                 cb_tick[port_cfg.clk_sel];

   // free running port counter, wraps after all ones
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         count_q <= '0;
      else if (!port_cfg.enable)
         count_q <= '0;
      else if (tick)
         count_q <= count_q + 1'b1;
   end

   assign port_count = count_q;

   // a timed transfer waits for the counter to reach its value
   assign time_ok = !port_cfg.timed || (count_q == port_cfg.time_val);

   // fifo sits between core and transfer register in either direction
   mp_fifo #(
      .WIDTH (XW),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .flush     (!port_cfg.enable),
      .in_valid  (f_in_valid),
      .in_ready  (f_in_ready),
      .in_data   (f_in_data),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (f_out_data)
   );

   // direction picks who fills and who drains; one-cycle handshakes
   always_comb
   begin
      if (port_cfg.dir_out)
      begin
         f_in_valid    = core_wr_valid && port_cfg.enable;
         f_in_data     = core_wr_data;
         core_wr_ready = f_in_ready && port_cfg.enable;
         core_rd_valid = 1'b0;
         f_out_ready   = load;
      end
      else
      begin
         f_in_valid    = wfull_q;
         f_in_data     = sh_q;
         core_wr_ready = 1'b0;
         core_rd_valid = f_out_valid;
         f_out_ready   = core_rd_ready;
      end
   end

   assign core_rd_data = f_out_data;

   // output load: empty serialiser, word waiting, counter at its time
   assign load = port_cfg.dir_out && tick && (left_q == '0) &&
                 f_out_valid && time_ok;

   // input condition compares the whole port width
   always_comb
   begin
      unique case (port_cfg.cond)
         mp_pkg::MP_COND_EQ:  cond_ok = (pin_in == port_cfg.cond_val[W-1:0]);
         mp_pkg::MP_COND_NEQ: cond_ok = (pin_in != port_cfg.cond_val[W-1:0]);
         default:             cond_ok = 1'b1;
      endcase
   end

   // first sample of a word waits for condition and time; all need strobe
   assign samp = !port_cfg.dir_out && tick && !wfull_q &&
                 (!port_cfg.strobe_in_en || strobe_from_external) &&
                 ((nin_q != '0) || (cond_ok && time_ok));

   // output serialiser shifts one port width per tick
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         sh_q   <= '0;
         left_q <= '0;
         drv_q  <= '0;
      end
      else if (!port_cfg.enable)
      begin
         left_q <= '0;
         drv_q  <= '0;
      end
      else if (port_cfg.dir_out)
      begin
         if (load)
         begin
            drv_q  <= f_out_data[W-1:0];
            sh_q   <= f_out_data >> W;
            left_q <= LAST;
         end
         else if (tick && (left_q != '0))
         begin
            drv_q  <= sh_q[W-1:0];
            sh_q   <= sh_q >> W;
            left_q <= left_q - 1'b1;
         end
      end
      else if (samp)
         sh_q <= {pin_in, sh_q[XW-1:W]};
   end

   // deserialiser counts samples; a full word stalls until fifo takes it
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         nin_q   <= '0;
         wfull_q <= 1'b0;
      end
      else if (!port_cfg.enable || port_cfg.dir_out)
      begin
         nin_q   <= '0;
         wfull_q <= 1'b0;
      end
      else
      begin
         if (samp)
            nin_q <= (nin_q == LAST) ? '0 : nin_q + 1'b1;
         if (samp && (nin_q == LAST))
            wfull_q <= 1'b1;
         else if (wfull_q && f_in_ready)
            wfull_q <= 1'b0;
      end
   end

   // timestamp at each word movement to or from the transfer register
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         ts_q <= '0;
      else if (load || (samp && (nin_q == LAST)))
         ts_q <= count_q;
   end

   assign timestamp = ts_q;

   // output strobe marks each new value put on the pins
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         stb_q <= 1'b0;
      else
         stb_q <= port_cfg.strobe_out_en &&
                  (load || (port_cfg.dir_out && tick && (left_q != '0)));
   end

   assign strobe_to_external = stb_q;

   // met condition is a scheduler event pulse, never an interrupt line
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         evt_q <= 1'b0;
      else
         evt_q <= samp && (nin_q == '0) &&
                  (port_cfg.cond != mp_pkg::MP_COND_NONE);
   end

   assign pin_event = evt_q;

   // drive only output ports; narrower ports and links take pins away
   assign drive = {W{live && port_cfg.dir_out}} & ~narrower_own;

   // open drain releases a one, forces a zero low
   always_comb
   begin
      for (int i = 0; i < W; i++)
      begin
         if (!drive[i])
         begin
            pin_out[i]  = 1'b0;
            pin_oe_n[i] = 1'b1;
         end
         else if (port_cfg.open_drain)
         begin
            pin_out[i]  = 1'b0;
            pin_oe_n[i] = drv_q[i];
         end
         else
         begin
            pin_out[i]  = drv_q[i];
            pin_oe_n[i] = 1'b0;
         end
      end
   end

   // pull-downs follow reset directly so they hold from power on
   assign pin_pulldown = rst;

   // widths outside the supported set stop elaboration, not silently misbehave
   generate
      if ((W != 1) && (W != 4) && (W != 8) && (W != 16) && (W != 32))
      begin : g_bad_width
         $error("mp_port width not supported");
      end
   endgenerate
endmodule : mp_port
`default_nettype wire

//--- mp_port_chk.sv
// concurrent checks on the ports of mp_port, attached by bind
// assumes one clock domain and the async high reset of the port
`timescale 1ns/10ps
`default_nettype none
`include "mp_params.svh"
module mp_port_chk #(
   parameter int W = `MP_PORT_W
) (
   input wire logic                 clk_sys,
   input wire logic                 rst,
   input wire mp_pkg::mp_port_cfg_t port_cfg,
   input wire logic                 link_en,
   input wire logic [W-1:0]         narrower_own,
   input wire logic                 core_wr_ready,
   input wire logic [`MP_CNT_W-1:0] port_count,
   input wire logic                 pin_event,
   input wire logic [W-1:0]         pin_out,
   input wire logic [W-1:0]         pin_oe_n,
   input wire logic                 pin_pulldown,
   input wire logic                 strobe_to_external
);
   default clocking cb_sys @(posedge clk_sys); endclocking
   default disable iff (rst);

   // an event is a single pulse, never a level
   sequence s_ev_pulse;
      pin_event ##1 !pin_event;
   endsequence

   a_count_step: assert property (
      (port_cfg.enable && !link_en && port_cfg.clk_sel == 3'h0)
      |=> port_count == $past(port_count) + 16'h1) else $error("count step wrong");
   a_count_clear: assert property (!port_cfg.enable |=> port_count == 16'h0)
      else $error("count not cleared");
   a_link_release: assert property (link_en |-> pin_oe_n == {W{1'b1}})
      else $error("pins driven under link");
   a_narrow_take: assert property ((narrower_own & ~pin_oe_n) == {W{1'b0}})
      else $error("taken pin still driven");
   a_input_dir: assert property (!port_cfg.dir_out |-> pin_oe_n == {W{1'b1}})
      else $error("input port drives pins");
   a_od_low: assert property (
      (port_cfg.open_drain && port_cfg.dir_out) |-> pin_out == {W{1'b0}})
      else $error("open drain drives high");
   a_event_pulse: assert property (pin_event |-> s_ev_pulse)
      else $error("event longer than a pulse");
   a_event_cond: assert property (
      pin_event |-> $past(port_cfg.cond) != mp_pkg::MP_COND_NONE)
      else $error("event without condition");
   a_wr_refuse: assert property (
      (!port_cfg.enable || !port_cfg.dir_out) |-> !core_wr_ready)
      else $error("write taken while off");
   a_strobe_off: assert property (
      (!port_cfg.strobe_out_en && !$past(port_cfg.strobe_out_en)) |-> !strobe_to_external)
      else $error("strobe while disabled");
   a_pd_run: assert property (!pin_pulldown)
      else $error("pull-down outside reset");
endmodule : mp_port_chk
bind mp_port mp_port_chk #(.W(W)) u_chk (.clk_sys, .rst, .port_cfg, .link_en, .narrower_own,
   .core_wr_ready, .port_count, .pin_event, .pin_out, .pin_oe_n, .pin_pulldown,
   .strobe_to_external);
`default_nettype wire

//--- mp_port_dummy_note.sv
`timescale 1ns/10ps
`default_nettype none
// stub kept empty on purpose is not needed
`default_nettype wire

//--- testbench.sv
// self-checking bench for mp_port with the board model on its pins
// assumes 20 MHz clk_sys and inputs driven 5 ns after each rising edge
`timescale 1ns/10ps
`default_nettype none
`include "mp_params.svh"
module testbench;
   logic clk_sys = 1'b0, rst = 1'b1, link_en = 1'b0, wr_v = 1'b0, rd_r = 1'b0;
   logic ext_en = 1'b0, cap_clr = 1'b0;
   logic wr_r, rd_v, pin_event, pd, stb_o, stb_i;
   logic [3:0] own = 4'h0, in_val = 4'h0, pin_in, pin_out, pin_oe_n, cap_n;
   logic [5:0] cb_src;
   logic [31:0] wr_d = 32'h0, rd_d, cap_word;
   logic [15:0] port_count, timestamp, c0;
   mp_pkg::mp_port_cfg_t cfg = '0;
   mp_pkg::mp_cb_cfg_t [5:0] cb = '0;
   int bad_count = 0, check_count = 0, ev_n = 0, n;
   always #25 clk_sys = ~clk_sys;
   mp_port uut (.clk_sys, .rst, .port_cfg(cfg), .cb_cfg(cb), .cb_pin_src(cb_src), .link_en,
      .narrower_own(own), .core_wr_valid(wr_v), .core_wr_ready(wr_r), .core_wr_data(wr_d),
      .core_rd_valid(rd_v), .core_rd_ready(rd_r), .core_rd_data(rd_d), .port_count,
      .timestamp, .pin_event, .pin_in, .pin_out, .pin_oe_n, .pin_pulldown(pd),
      .strobe_from_external(stb_i), .strobe_to_external(stb_o));
   mp_ext_model u_ext (.clk_sys, .rst, .pin_out, .pin_oe_n, .strobe_to_external(stb_o),
      .in_val, .ext_en, .cap_clr, .pin_in, .cb_pin_src(cb_src), .strobe_from_external(stb_i),
      .cap_word, .cap_n);
   always @(posedge clk_sys) if (pin_event === 1'b1) ev_n++;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("ERROR %0t seen %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys);
      #5;
   endtask : cyc
   // request held until ready is seen high ahead of the taking edge
   task automatic wr(input logic [31:0] d);
      wr_v = 1'b1; wr_d = d; n = 0;
      while (wr_r !== 1'b1 && n < 50) begin cyc(1); n++; end
      chk(wr_r, 1'b1);
      cyc(1); wr_v = 1'b0; cyc(1);
   endtask : wr
   task automatic t_count;
      cfg = '0; cfg.enable = 1'b1; cb[1].div = 8'h01; cb[2].from_pin = 1'b1;
      cyc(1); c0 = port_count; cyc(10); chk(port_count, c0 + 16'd10);
      cfg.clk_sel = 3'h1; cyc(1); c0 = port_count; cyc(10); chk(port_count, c0 + 16'd5);
      cfg.clk_sel = 3'h2; ext_en = 1'b1; cyc(8); c0 = port_count; cyc(40);
      chk(port_count, c0 + 16'd10);
      ext_en = 1'b0; cfg.clk_sel = 3'h7; cyc(1); c0 = port_count; cyc(6); chk(port_count, c0);
      cfg = '0; cyc(2); chk(port_count, 16'h0);
   endtask : t_count
   task automatic t_out(input logic od, input logic [3:0] tk, input logic [31:0] w, input logic tm);
      cfg = '0; cfg.enable = 1'b1; cfg.dir_out = 1'b1; cfg.strobe_out_en = 1'b1;
      cfg.open_drain = od; cfg.timed = tm; own = tk; cap_clr = 1'b1; cyc(1); cap_clr = 1'b0;
      cfg.time_val = port_count + 16'h0020; wr(w); n = 0;
      while (cap_n !== 4'h8 && n < 200) begin cyc(1); n++; end
      chk(cap_word, w | {8{tk}});
      if (tm) chk(timestamp, cfg.time_val);
      cyc(4); chk(cap_n, 4'h8);
      cfg = '0; own = 4'h0; cyc(2);
   endtask : t_out
   task automatic t_in;
      cfg = '0; cfg.enable = 1'b1; cfg.cond = mp_pkg::MP_COND_EQ; cfg.cond_val = 32'h6;
      in_val = 4'h3; cyc(12); chk(rd_v, 1'b0); chk(ev_n, 0);
      in_val = 4'h6; n = 0;
      while (rd_v !== 1'b1 && n < 60) begin cyc(1); n++; end
      chk(rd_d, 32'h66666666); chk(ev_n, 1);
      rd_r = 1'b1; cyc(1); rd_r = 1'b0; cfg = '0; cyc(2); chk(rd_v, 1'b0);
      cfg.enable = 1'b1; cfg.cond = mp_pkg::MP_COND_NEQ; cfg.cond_val = 32'h5;
      cfg.strobe_in_en = 1'b1; in_val = 4'ha; cyc(12); chk(rd_v, 1'b0);
      ext_en = 1'b1; n = 0;
      while (rd_v !== 1'b1 && n < 80) begin cyc(1); n++; end
      chk(rd_d, 32'haaaaaaaa);
      rd_r = 1'b1; cyc(1); rd_r = 1'b0; cfg = '0; ext_en = 1'b0; cyc(2);
   endtask : t_in
   task automatic t_full;
      cfg = '0; cfg.enable = 1'b1; cfg.dir_out = 1'b1; cfg.clk_sel = 3'h7;
      cap_clr = 1'b1; cyc(1); cap_clr = 1'b0;
      for (int i = 0; i < `MP_FIFO_DEP; i++) wr(32'h11111111 * i);
      chk(wr_r, 1'b0);
      link_en = 1'b1; cfg.clk_sel = 3'h0; cyc(1); c0 = port_count; cyc(5);
      chk(pin_oe_n, 4'hf); chk(port_count, c0); chk(cap_n, 4'h0);
      link_en = 1'b0; cfg = '0; cyc(2); chk(wr_r, 1'b0);
   endtask : t_full
   task automatic wrap_up;
      if (bad_count == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up
   initial
   begin
      cyc(12);
      chk(pd, 1'b1); chk(pin_oe_n, 4'hf); chk(port_count, 16'h0);
      rst = 1'b0; cyc(1); chk(pd, 1'b0);
      t_count();
      t_out(1'b0, 4'h0, 32'h9c3a5e71, 1'b0);
      t_out(1'b1, 4'h0, 32'h0f5a3c96, 1'b0);
      t_out(1'b0, 4'h2, 32'h84210c1d, 1'b1);
      t_in();
      t_full();
      wrap_up();
   end
   // hang guard, well past the few hundred cycles the tests need
   initial
   begin
      #1000000;
      bad_count++;
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
